// ===== verilog/clock_unit_consts.svh
// offsets, fields, reset values and counts of the clock unit
// Behaviour
// - firmware picks master source without glitches
// - oscillator after reset, pll only when locked
// - pll multiplier limited to 96 MHz output
// - return to oscillator, then pll power down
// - slow real-time oscillator selectable as master
// - reference clock divides master by up to 1024
// - high bus clock is reference by 1/2/4
// - peripheral bus clock is reference by 1/2/4/8
// - flash interface clock full rate, optionally halved
// - baud reference from master, optionally halved
// - external memory clock equals or halves high bus
// - usb clock from master, halved master, pin
// - phy clock forwards the oscillator when enabled, whatever its frequency
// - calibration pin carries slow clock by 8
// - usb and timers may use external pins
// - run mode after reset, masks gate clocks
// - interrupt mode runs cpu full speed
// - idle stops cpu and flash, masks snapshotted
// - idle ends on reset, interrupt or wake-up
// - sleep stops all but slow oscillator, pll off
// - sleep exits: resets except watchdog, alarm, wake-up
// - debug keeps every clock running except the pll, which sleep turns off
// - clock unit events ored into one request
`ifndef CLOCK_UNIT_CONSTS_SVH
`define CLOCK_UNIT_CONSTS_SVH
`define ADR_CTL      8'h00
`define ADR_DIV      8'h04
`define ADR_MASK     8'h08
`define ADR_PWR      8'h0c
`define ADR_STAT     8'h10
`define ADR_PLL      8'h14
`define SRC_OSC      2'h0
`define SRC_PLL      2'h1
`define SRC_RTC      2'h2
`define CTL_SEL      1:0
`define CTL_PLL_EN   2
`define CTL_IRQ_MODE 3
`define CTL_USB      5:4
`define CTL_PHY_EN   6
`define CTL_CAL_EN   7
`define CTL_T01_EXT  8
`define CTL_T23_EXT  9
`define CTL_REST     9:3
`define DIV_REF      9:0
`define DIV_HBUS     11:10
`define DIV_PBUS     13:12
`define DIV_FLASH    14
`define DIV_BAUD     15
`define DIV_EXTMEM   16
`define PWR_IDLE     0
`define PWR_SLEEP    1
`define USB_MASTER   2'h0
`define USB_HALF     2'h1
`define USB_PIN      2'h2
`define CTL_RESET    10'h000
`define DIV_RESET    17'h00000
`define MASK_RESET   6'h3f
`define MULT_RESET   8'h01
`define N_ONE        11'h001
`define N_HALF       11'h002
`define N_QUARTER    11'h004
`define N_CAL        11'h008
`endif

// ===== verilog/clock_unit_pkg.sv
// types of the clock unit
`default_nettype none
package clock_unit_pkg;
    typedef enum logic [2:0] {
        MODE_RUN   = 3'b001,
        MODE_IDLE  = 3'b010,
        MODE_SLEEP = 3'b100
    } mode_t;
    typedef enum logic [2:0] {
        SW_IDLE = 3'b001,
        SW_DROP = 3'b010,
        SW_PICK = 3'b100
    } switch_t;
    typedef struct packed {
        logic osc;
        logic pll;
        logic rtc;
        logic lock;
        logic usb_ext;
        logic t01_ext;
        logic t23_ext;
        logic irq;
        logic irq_busy;
        logic wake;
        logic alarm;
        logic debug;
        logic rst_wake;
        logic rst_wdog;
    } ext_in_t;
    typedef logic [10:0] count_t;
endpackage
`default_nettype wire

// ===== verilog/clock_unit.sv
// clock selection, dividers, gating and power modes
`timescale 1ns/1ns
`default_nettype none
`include "clock_unit_consts.svh"
module clock_unit #(
    parameter int OSC_FREQ_KHZ = 25000,
    parameter int PLL_MAX_KHZ  = 96000
) (
    input  wire logic        CLOCK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    input  wire logic        MAIN_OSC_CLOCK_IN,
    input  wire logic        PLL_CLOCK_IN,
    input  wire logic        SLOW_OSC_CLOCK_IN,
    input  wire logic        PLL_LOCK_IN,
    input  wire logic        USB_EXT_CLOCK_PIN_IN,
    input  wire logic        TIMER01_EXT_CLOCK_PIN_IN,
    input  wire logic        TIMER23_EXT_CLOCK_PIN_IN,
    input  wire logic        IRQ_PENDING_IN,
    input  wire logic        IRQ_SERVICE_IN,
    input  wire logic        WAKEUP_IN,
    input  wire logic        RTC_ALARM_IN,
    input  wire logic        DEBUG_ACTIVE_IN,
    input  wire logic        RESET_WAKE_IN,
    input  wire logic        RESET_WATCHDOG_IN,
    output logic             MASTER_CLOCK_OUT,
    output logic             CPU_CLOCK_OUT,
    output logic             HBUS_CLOCK_OUT,
    output logic             PBUS_CLOCK_OUT,
    output logic             FLASH_INTERFACE_CLOCK_OUT,
    output logic             EXTERNAL_MEMORY_INTERFACE_CLOCK_OUT,
    output logic             BAUD_REFERENCE_CLOCK_OUT,
    output logic             USB_CLOCK_OUT,
    output logic             TIMER01_CLOCK_OUT,
    output logic             TIMER23_CLOCK_OUT,
    output logic             PHY_CLOCK_PIN_OUT,
    output logic             CALIBRATION_PIN_OUT,
    output logic             PLL_ENABLE_OUT,
    output logic      [7:0]  PLL_MULT_OUT,
    output logic             MAIN_OSC_ENABLE_OUT,
    output logic             CLOCK_IRQ_OUT
);

    // ==========================================================
    // functions
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] onehot(input logic [1:0] s);
        case (s)
            `SRC_OSC: onehot = 3'b001;
            `SRC_PLL: onehot = 3'b010;
            default:  onehot = 3'b100;
        endcase
    endfunction

    function automatic clock_unit_pkg::count_t pow2(input logic [1:0] c);
        case (c)
            2'h0:    pow2 = `N_ONE;
            2'h1:    pow2 = `N_HALF;
            2'h2:    pow2 = `N_QUARTER;
            default: pow2 = `N_CAL;
        endcase
    endfunction

    // ==========================================================
    // declarations
    clock_unit_pkg::ext_in_t raw;
    clock_unit_pkg::ext_in_t sync1;
    clock_unit_pkg::ext_in_t s2;
    clock_unit_pkg::mode_t   mode;
    clock_unit_pkg::switch_t sw;
    clock_unit_pkg::count_t  div_n   [8];
    clock_unit_pkg::count_t  div_cnt [8];
    logic [7:0]  div_clk;
    logic [7:0]  div_prev;
    logic [7:0]  src_edge;
    logic [9:0]  ctl;
    logic [16:0] div;
    logic [5:0]  mask;
    logic [5:0]  idle_mask;
    logic [7:0]  mult;
    logic [2:0]  act;
    logic [2:0]  lvl;
    logic [1:0]  cur_sel;
    logic [1:0]  tgt;
    logic [1:0]  flags;
    logic [1:0]  set_f;
    logic [1:0]  clr_f;
    logic        master;
    logic        master_prev;
    logic        rtc_prev;
    logic        lock_prev;
    logic        sw_done;
    logic        ack;
    logic        req;
    logic        wr;
    logic        go_idle;
    logic        go_sleep;
    logic        sel_ok;
    logic        pll_busy;
    logic        mult_ok;
    logic [31:0] m_ctl;
    logic [31:0] m_div;
    logic [31:0] m_mask;
    logic [31:0] m_pll;
    logic [31:0] next_rd;
    logic        dbg;
    logic        on_cpu;
    logic        on_master;
    logic [5:0]  p_on;
    logic        cpu_src;
    logic        next_usb;

    // ==========================================================
    // input synchronisers
    assign raw = '{osc: MAIN_OSC_CLOCK_IN, pll: PLL_CLOCK_IN,
                   rtc: SLOW_OSC_CLOCK_IN, lock: PLL_LOCK_IN,
                   usb_ext: USB_EXT_CLOCK_PIN_IN,
                   t01_ext: TIMER01_EXT_CLOCK_PIN_IN,
                   t23_ext: TIMER23_EXT_CLOCK_PIN_IN,
                   irq: IRQ_PENDING_IN, irq_busy: IRQ_SERVICE_IN,
                   wake: WAKEUP_IN, alarm: RTC_ALARM_IN,
                   debug: DEBUG_ACTIVE_IN, rst_wake: RESET_WAKE_IN,
                   rst_wdog: RESET_WATCHDOG_IN};

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sync1 <= '0;
            s2    <= '0;
        end else begin
            sync1 <= raw;
            s2    <= sync1;
        end
    end

    assign dbg = s2.debug;
    assign lvl = {s2.rtc, s2.pll, s2.osc};

    // ==========================================================
    // wishbone decode
    assign req      = WB_CYC_IN & WB_STB_IN & ~ack;
    assign wr       = req & WB_WE_IN;
    assign m_ctl    = wmerge({22'h0, ctl}, WB_DAT_IN, WB_SEL_IN);
    assign m_div    = wmerge({15'h0, div}, WB_DAT_IN, WB_SEL_IN);
    assign m_mask   = wmerge({26'h0, mask}, WB_DAT_IN, WB_SEL_IN);
    assign m_pll    = wmerge({24'h0, mult}, WB_DAT_IN, WB_SEL_IN);
    assign go_idle  = wr & (WB_ADR_IN == `ADR_PWR) & WB_SEL_IN[0]
                      & WB_DAT_IN[`PWR_IDLE] & (mode == clock_unit_pkg::MODE_RUN);
    assign go_sleep = wr & (WB_ADR_IN == `ADR_PWR) & WB_SEL_IN[0]
                      & WB_DAT_IN[`PWR_SLEEP] & (mode == clock_unit_pkg::MODE_RUN);
    assign sel_ok   = (m_ctl[`CTL_SEL] == `SRC_OSC) | (m_ctl[`CTL_SEL] == `SRC_RTC)
                      | ((m_ctl[`CTL_SEL] == `SRC_PLL) & s2.lock & ctl[`CTL_PLL_EN]);
    assign pll_busy = (ctl[`CTL_SEL] == `SRC_PLL) | (cur_sel == `SRC_PLL)
                      | (tgt == `SRC_PLL);
    assign mult_ok  = (m_pll[7:0] != 8'h00)
                      & (OSC_FREQ_KHZ * int'(m_pll[7:0]) <= PLL_MAX_KHZ);
    assign clr_f    = (wr & (WB_ADR_IN == `ADR_STAT) & WB_SEL_IN[0])
                      ? WB_DAT_IN[1:0] : 2'h0;
    assign set_f    = {sw_done, s2.lock & ~lock_prev};

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ack <= 1'b0;
        end else begin
            ack <= req;
        end
    end

    always_comb begin
        next_rd = 32'h0;
        case (WB_ADR_IN)
            `ADR_CTL:  next_rd = {22'h0, ctl};
            `ADR_DIV:  next_rd = {15'h0, div};
            `ADR_MASK: next_rd = {26'h0, mask};
            `ADR_PWR:  next_rd = {29'h0, mode};
            `ADR_STAT: next_rd = {26'h0, sw != clock_unit_pkg::SW_IDLE, cur_sel,
                                  s2.lock, flags};
            `ADR_PLL:  next_rd = {24'h0, mult};
            default:   next_rd = 32'h0;
        endcase
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            WB_DAT_OUT <= 32'h0;
        end else if (req & ~WB_WE_IN) begin
            WB_DAT_OUT <= next_rd;
        end
    end

    // ==========================================================
    // control register
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ctl <= `CTL_RESET;
        end else if (go_sleep) begin
            ctl[`CTL_PLL_EN] <= 1'b0;
            if (ctl[`CTL_SEL] == `SRC_PLL) begin
                ctl[`CTL_SEL] <= `SRC_OSC;
            end
        end else if (wr & (WB_ADR_IN == `ADR_CTL)) begin
            ctl[`CTL_REST] <= m_ctl[`CTL_REST];
            if (sel_ok) begin
                ctl[`CTL_SEL] <= m_ctl[`CTL_SEL];
            end
            if (m_ctl[`CTL_PLL_EN] | ~pll_busy) begin
                ctl[`CTL_PLL_EN] <= m_ctl[`CTL_PLL_EN];
            end
        end
    end

    // ==========================================================
    // divisor, mask and pll registers
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            div  <= `DIV_RESET;
            mask <= `MASK_RESET;
            mult <= `MULT_RESET;
        end else if (wr) begin
            if (WB_ADR_IN == `ADR_DIV) begin
                div <= m_div[16:0];
            end
            if (WB_ADR_IN == `ADR_MASK) begin
                mask <= m_mask[5:0];
            end
            if ((WB_ADR_IN == `ADR_PLL) & mult_ok) begin
                mult <= m_pll[7:0];
            end
        end
    end

    // ==========================================================
    // event flags
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            flags     <= 2'h0;
            lock_prev <= 1'b0;
        end else begin
            lock_prev <= s2.lock;
            flags     <= (flags & ~clr_f) | set_f;
        end
    end

    // ==========================================================
    // power mode machine
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            mode      <= clock_unit_pkg::MODE_RUN;
            idle_mask <= `MASK_RESET;
        end else begin
            case (mode)
                clock_unit_pkg::MODE_RUN: begin
                    if (go_sleep) begin
                        mode <= clock_unit_pkg::MODE_SLEEP;
                    end else if (go_idle) begin
                        mode      <= clock_unit_pkg::MODE_IDLE;
                        idle_mask <= mask;
                    end
                end
                clock_unit_pkg::MODE_IDLE: begin
                    if (s2.irq | s2.wake | s2.rst_wake | s2.rst_wdog) begin
                        mode <= clock_unit_pkg::MODE_RUN;
                    end
                end
                clock_unit_pkg::MODE_SLEEP: begin
                    if (s2.rst_wake | s2.alarm | s2.wake) begin
                        mode <= clock_unit_pkg::MODE_RUN;
                    end
                end
                default: mode <= clock_unit_pkg::MODE_RUN;
            endcase
        end
    end

    // ==========================================================
    // glitch-free source switch
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            sw      <= clock_unit_pkg::SW_IDLE;
            act     <= 3'b001;
            cur_sel <= `SRC_OSC;
            tgt     <= `SRC_OSC;
            sw_done <= 1'b0;
        end else begin
            sw_done <= 1'b0;
            case (sw)
                clock_unit_pkg::SW_IDLE: begin
                    if (ctl[`CTL_SEL] != cur_sel) begin
                        tgt <= ctl[`CTL_SEL];
                        sw  <= clock_unit_pkg::SW_DROP;
                    end
                end
                clock_unit_pkg::SW_DROP: begin
                    if ((lvl & onehot(cur_sel)) == 3'b000) begin
                        act <= 3'b000;
                        sw  <= clock_unit_pkg::SW_PICK;
                    end
                end
                clock_unit_pkg::SW_PICK: begin
                    if ((lvl & onehot(tgt)) == 3'b000) begin
                        act     <= onehot(tgt);
                        cur_sel <= tgt;
                        sw_done <= 1'b1;
                        sw      <= clock_unit_pkg::SW_IDLE;
                    end
                end
                default: sw <= clock_unit_pkg::SW_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            master      <= 1'b0;
            master_prev <= 1'b0;
            rtc_prev    <= 1'b0;
            div_prev    <= 8'h00;
        end else begin
            master      <= |(act & lvl);
            master_prev <= master;
            rtc_prev    <= s2.rtc;
            div_prev    <= div_clk;
        end
    end

    // ==========================================================
    // dividers: 0 ref, 1 hbus, 2 pbus, 3 flash, 4 baud,
    // 5 external memory, 6 usb half, 7 calibration
    assign src_edge = {s2.rtc ^ rtc_prev, master ^ master_prev,
                       div_clk[1] ^ div_prev[1], master ^ master_prev,
                       {3{div_clk[0] ^ div_prev[0]}}, master ^ master_prev};

    always_comb begin
        div_n[0] = {1'b0, div[`DIV_REF]} + `N_ONE;
        div_n[1] = (div[`DIV_HBUS] == 2'h3) ? `N_QUARTER : pow2(div[`DIV_HBUS]);
        div_n[2] = pow2(div[`DIV_PBUS]);
        div_n[3] = div[`DIV_FLASH] ? `N_HALF : `N_ONE;
        div_n[4] = div[`DIV_BAUD] ? `N_HALF : `N_ONE;
        div_n[5] = div[`DIV_EXTMEM] ? `N_HALF : `N_ONE;
        div_n[6] = `N_HALF;
        div_n[7] = `N_CAL;
    end

    for (genvar i = 0; i < 8; i++) begin : g_div
        always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
            if (RESET_IN) begin
                div_cnt[i] <= 11'h000;
                div_clk[i] <= 1'b0;
            end else if (src_edge[i]) begin
                if (div_cnt[i] >= div_n[i] - `N_ONE) begin
                    div_cnt[i] <= 11'h000;
                    div_clk[i] <= ~div_clk[i];
                end else begin
                    div_cnt[i] <= div_cnt[i] + `N_ONE;
                end
            end
        end
    end

    // ==========================================================
    // gating
    assign on_master = dbg | (mode != clock_unit_pkg::MODE_SLEEP);
    assign on_cpu    = dbg | (mode == clock_unit_pkg::MODE_RUN);
    assign p_on      = {6{dbg}} | ((mode == clock_unit_pkg::MODE_RUN) ? mask
                       : (mode == clock_unit_pkg::MODE_IDLE) ? idle_mask : 6'h00);
    assign cpu_src   = (ctl[`CTL_IRQ_MODE] & s2.irq_busy) ? master : div_clk[0];

    always_comb begin
        case (ctl[`CTL_USB])
            `USB_MASTER: next_usb = master;
            `USB_HALF:   next_usb = div_clk[6];
            `USB_PIN:    next_usb = s2.usb_ext;
            default:     next_usb = 1'b0;
        endcase
    end

    // ==========================================================
    // output registers
    always_ff @(posedge CLOCK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            MASTER_CLOCK_OUT                    <= 1'b0;
            CPU_CLOCK_OUT                       <= 1'b0;
            HBUS_CLOCK_OUT                      <= 1'b0;
            PBUS_CLOCK_OUT                      <= 1'b0;
            FLASH_INTERFACE_CLOCK_OUT           <= 1'b0;
            EXTERNAL_MEMORY_INTERFACE_CLOCK_OUT <= 1'b0;
            BAUD_REFERENCE_CLOCK_OUT            <= 1'b0;
            USB_CLOCK_OUT                       <= 1'b0;
            TIMER01_CLOCK_OUT                   <= 1'b0;
            TIMER23_CLOCK_OUT                   <= 1'b0;
            PHY_CLOCK_PIN_OUT                   <= 1'b0;
            CALIBRATION_PIN_OUT                 <= 1'b0;
            PLL_ENABLE_OUT                      <= 1'b0;
            PLL_MULT_OUT                        <= `MULT_RESET;
            MAIN_OSC_ENABLE_OUT                 <= 1'b1;
            CLOCK_IRQ_OUT                       <= 1'b0;
        end else begin
            MASTER_CLOCK_OUT          <= master & on_master;
            CPU_CLOCK_OUT             <= cpu_src & on_cpu;
            HBUS_CLOCK_OUT            <= div_clk[1] & p_on[0];
            PBUS_CLOCK_OUT            <= div_clk[2] & p_on[1];
            FLASH_INTERFACE_CLOCK_OUT <= div_clk[3] & on_cpu;
            EXTERNAL_MEMORY_INTERFACE_CLOCK_OUT <= div_clk[5] & p_on[2];
            BAUD_REFERENCE_CLOCK_OUT  <= div_clk[4] & p_on[3];
            USB_CLOCK_OUT             <= next_usb & p_on[4];
            TIMER01_CLOCK_OUT <= (ctl[`CTL_T01_EXT] ? s2.t01_ext : div_clk[2])
                                 & p_on[5];
            TIMER23_CLOCK_OUT <= (ctl[`CTL_T23_EXT] ? s2.t23_ext : div_clk[2])
                                 & p_on[5];
            PHY_CLOCK_PIN_OUT   <= s2.osc & ctl[`CTL_PHY_EN] & on_master;
            CALIBRATION_PIN_OUT <= div_clk[7] & ctl[`CTL_CAL_EN];
            PLL_ENABLE_OUT      <= ctl[`CTL_PLL_EN] & on_master;
            PLL_MULT_OUT        <= mult;
            MAIN_OSC_ENABLE_OUT <= on_master;
            CLOCK_IRQ_OUT       <= |flags;
        end
    end

    assign WB_ACK_OUT = ack;

endmodule
`default_nettype wire

// ===== dv/clock_unit_asserts.sv
// port assertions of the clock unit
`timescale 1ns/1ns
`default_nettype none
module clock_unit_asserts #(
    parameter int OSC_FREQ_KHZ = 25000,
    parameter int PLL_MAX_KHZ  = 96000
) (
    input wire logic       CLOCK_IN,
    input wire logic       RESET_IN,
    input wire logic       WB_CYC_IN,
    input wire logic       WB_STB_IN,
    input wire logic       WB_ACK_OUT,
    input wire logic [7:0] PLL_MULT_OUT,
    input wire logic       PLL_ENABLE_OUT,
    input wire logic       MAIN_OSC_ENABLE_OUT,
    input wire logic       HBUS_CLOCK_OUT,
    input wire logic       DEBUG_ACTIVE_IN,
    input wire logic       WAKEUP_IN,
    input wire logic       RTC_ALARM_IN,
    input wire logic       RESET_WAKE_IN
);
    // ====
    // properties
    default clocking @(posedge CLOCK_IN); endclocking
    default disable iff (RESET_IN);
    property p_ack_resp; WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack");
    property p_ack_once; WB_ACK_OUT |=> !WB_ACK_OUT; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_mult_range; PLL_MULT_OUT != 8'h00 && OSC_FREQ_KHZ * PLL_MULT_OUT <= PLL_MAX_KHZ;
    endproperty
    a_mult_range: assert property (p_mult_range) else $error("multiplier out of range");
    property p_mult_cause; $changed(PLL_MULT_OUT) |-> WB_ACK_OUT || $past(WB_ACK_OUT); endproperty
    a_mult_cause: assert property (p_mult_cause) else $error("multiplier moved");
    property p_pll_cause; $rose(PLL_ENABLE_OUT) |-> WB_ACK_OUT || $past(WB_ACK_OUT); endproperty
    a_pll_cause: assert property (p_pll_cause) else $error("pll powered alone");
    property p_sleep_pll; !MAIN_OSC_ENABLE_OUT |-> !PLL_ENABLE_OUT; endproperty
    a_sleep_pll: assert property (p_sleep_pll) else $error("pll on in sleep");
    property p_sleep_quiet; !DEBUG_ACTIVE_IN [*4] ##0 !MAIN_OSC_ENABLE_OUT [*2] |-> !HBUS_CLOCK_OUT;
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("clock in sleep");
    property p_sleep_hold;
        (!WAKEUP_IN && !RTC_ALARM_IN && !RESET_WAKE_IN && !DEBUG_ACTIVE_IN) [*6]
            ##0 !MAIN_OSC_ENABLE_OUT
            |=> !MAIN_OSC_ENABLE_OUT;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left alone");
    c_ack: cover property (WB_ACK_OUT);
    c_sleep: cover property ($fell(MAIN_OSC_ENABLE_OUT));
    c_mult: cover property ($changed(PLL_MULT_OUT));
endmodule
bind clock_unit clock_unit_asserts #(.OSC_FREQ_KHZ(OSC_FREQ_KHZ), .PLL_MAX_KHZ(PLL_MAX_KHZ)) chk (
    .CLOCK_IN, .RESET_IN, .WB_CYC_IN, .WB_STB_IN, .WB_ACK_OUT, .PLL_MULT_OUT, .PLL_ENABLE_OUT,
    .MAIN_OSC_ENABLE_OUT, .HBUS_CLOCK_OUT, .DEBUG_ACTIVE_IN, .WAKEUP_IN, .RTC_ALARM_IN,
    .RESET_WAKE_IN);
`default_nettype wire

// ===== dv/test_clock_unit.sv
// self-checking bench of the clock unit
`timescale 1ns/1ns
`default_nettype none
module test_clock_unit;
    // ====
    // design and stimulus
    logic                    clk, rst, cyc, stb, we, ack, cpu, oen, pen, irq, p;
    logic [7:0]              adr, mult, em;
    logic [31:0]             dat, dout, q, r;
    logic [3:0]              cnt, sel;
    clock_unit_pkg::ext_in_t ev;
    int                      fail_count, checks, cycles, n;
    clock_unit dut (
        .CLOCK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
        .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
        .MAIN_OSC_CLOCK_IN(cnt[1]), .PLL_CLOCK_IN(cnt[0]), .SLOW_OSC_CLOCK_IN(cnt[3]),
        .PLL_LOCK_IN(ev.lock), .USB_EXT_CLOCK_PIN_IN(cnt[2]), .TIMER01_EXT_CLOCK_PIN_IN(cnt[1]),
        .TIMER23_EXT_CLOCK_PIN_IN(cnt[2]), .IRQ_PENDING_IN(ev.irq), .IRQ_SERVICE_IN(ev.irq_busy),
        .WAKEUP_IN(ev.wake), .RTC_ALARM_IN(ev.alarm), .DEBUG_ACTIVE_IN(ev.debug),
        .RESET_WAKE_IN(ev.rst_wake), .RESET_WATCHDOG_IN(ev.rst_wdog), .MASTER_CLOCK_OUT(),
        .CPU_CLOCK_OUT(cpu), .HBUS_CLOCK_OUT(), .PBUS_CLOCK_OUT(), .FLASH_INTERFACE_CLOCK_OUT(),
        .EXTERNAL_MEMORY_INTERFACE_CLOCK_OUT(), .BAUD_REFERENCE_CLOCK_OUT(), .USB_CLOCK_OUT(),
        .TIMER01_CLOCK_OUT(), .TIMER23_CLOCK_OUT(), .PHY_CLOCK_PIN_OUT(),
        .CALIBRATION_PIN_OUT(), .PLL_ENABLE_OUT(pen), .PLL_MULT_OUT(mult),
        .MAIN_OSC_ENABLE_OUT(oen), .CLOCK_IRQ_OUT(irq));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cnt <= cnt + 4'h1;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            results();
        end
    end
    // ====
    // tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("unexpected %0t got %h want %h", $time, got, exp);
            fail_count++;
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = dout;
        {cyc, stb} <= 2'b00;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q & m, e);
    endtask
    task src_is(input logic [1:0] s);
        for (int i = 0; i < 30; i++) begin
            wb(1'b0, 8'h10, 32'h0);
            if (q[4:3] === s) break;
        end
        chk(q[4:3], s);
    endtask
    task count_cpu;
        n = 0;
        p = cpu;
        repeat (16) begin
            @(posedge clk);
            if (cpu !== p) n++;
            p = cpu;
        end
    endtask
    function automatic logic [7:0] exp_mult(input logic [7:0] o, input logic [7:0] m);
        return (m != 8'h00 && int'(m) * 25000 <= 96000) ? m : o;
    endfunction
    task results;
        if (fail_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ====
    // sequence
    initial begin
        rst = 1'b1;
        {cyc, stb, we, adr, dat, cnt, ev, p} = '0;
        {fail_count, checks, cycles} = '0;
        {em, sel} = {8'h01, 4'hf};
        void'($urandom(32'hb93561ff));
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({pen, mult, oen, irq}, {1'b0, 8'h01, 1'b1, 1'b0});
        rd(8'h00, 32'hffffffff, 32'h0);
        rd(8'h08, 32'h3f, 32'h3f);
        rd(8'h0c, 32'h7, 32'h1);
        rd(8'h20, 32'hffffffff, 32'h0);
        sel <= 4'he;
        wb(1'b1, 8'h08, 32'h0);
        sel <= 4'hf;
        rd(8'h08, 32'h3f, 32'h3f);
        for (int i = 0; i < 12; i++) begin
            r = $urandom;
            if (i < 4) wb(1'b1, 8'h08, r);
            if (i < 4) rd(8'h08, 32'h3f, r & 32'h3f);
            r = (i > 2) ? r % 8 : (i == 0) ? 0 : i + 2;
            em = exp_mult(em, r[7:0]);
            wb(1'b1, 8'h14, r);
            rd(8'h14, 32'hff, {24'h0, em});
        end
        wb(1'b1, 8'h00, 32'h5);
        repeat (30) @(posedge clk);
        rd(8'h10, 32'h18, 32'h0);
        ev.lock <= 1'b1;
        wb(1'b1, 8'h00, 32'h4);
        wb(1'b1, 8'h00, 32'h5);
        src_is(2'h1);
        chk(irq, 1'b1);
        wb(1'b1, 8'h10, 32'h3);
        chk(irq, 1'b0);
        wb(1'b1, 8'h00, 32'h4);
        src_is(2'h0);
        wb(1'b1, 8'h00, 32'h0);
        chk(pen, 1'b0);
        wb(1'b1, 8'h00, 32'h2);
        src_is(2'h2);
        wb(1'b1, 8'h00, 32'h0);
        src_is(2'h0);
        count_cpu();
        chk(n, 8);
        wb(1'b1, 8'h04, 32'h1);
        count_cpu();
        chk(n, 4);
        ev.irq_busy <= 1'b1;
        wb(1'b1, 8'h00, 32'h8);
        count_cpu();
        chk(n, 8);
        ev.irq_busy <= 1'b0;
        repeat (4) @(posedge clk);
        count_cpu();
        chk(n, 4);
        wb(1'b1, 8'h0c, 32'h1);
        rd(8'h0c, 32'h7, 32'h2);
        count_cpu();
        chk(n, 0);
        ev.irq <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h0c, 32'h7, 32'h1);
        {ev.irq, ev.debug} <= 2'b01;
        wb(1'b1, 8'h0c, 32'h1);
        count_cpu();
        chk(n != 0, 1'b1);
        ev.wake <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h0c, 32'h7, 32'h1);
        {ev.wake, ev.debug} <= 2'b00;
        wb(1'b1, 8'h0c, 32'h2);
        rd(8'h0c, 32'h7, 32'h4);
        chk({oen, pen}, 2'b00);
        ev.rst_wdog <= 1'b1;
        repeat (5) @(posedge clk);
        rd(8'h0c, 32'h7, 32'h4);
        {ev.rst_wdog, ev.alarm} <= 2'b01;
        repeat (5) @(posedge clk);
        rd(8'h0c, 32'h7, 32'h1);
        chk(oen, 1'b1);
        results();
    end
endmodule
`default_nettype wire
